// ===== logic/dds_pkg.sv
/*
 * Shared constants for the synthesis core and its clock control: control word fields,
 * reset values, multiplier limits and the sync divider length.
 * Assumes one system clock domain and a synchronous active-high reset.
 */
// Operation
// - Reset returns all control state to defaults.
// - Keying direction pin sampled on sync clock.
// - Two profile pins pick one of four.
// - Profile change issues an internal register transfer.
// - Device drives a sync clock output pin.
// - Phase accumulator wraps at two to thirty-two.
// - Phase maps through cosine to DAC sample.
// - Zero tuning word holds phase; clear bit zeroes.
// - Active clear bit one, buffered copy zero.
// - Multiplier field bits 7..3, values 4..20 multiply.
// - Multiplier outside 4..20 bypasses, PLL powered down.
// - Oscillator mode pin enables crystal oscillator.
// - Word one bit 4 stops system clock.
// - Word two bit 9 enables oscillator output.
// - System clock reference times M, reference, or zero.
// - Sync clock runs at quarter system rate.
// - Update strobe rising edge loads active registers.
package dds_pkg;
    // Control word one fields.
    localparam int CW1_CLKIN_OFF_BIT  = 4;
    localparam int CW1_CLR_PHASE_BIT  = 10;
    // Control word two fields.
    localparam int CW2_MULT_LSB       = 3;
    localparam int CW2_MULT_MSB       = 7;
    localparam int CW2_XTAL_OUT_BIT   = 9;
    localparam logic [4:0] MULT_MIN   = 5'h04;
    localparam logic [4:0] MULT_MAX   = 5'h14;
    // Reset values: active word one starts with clear-phase set, buffer clear.
    localparam logic [31:0] CW1_ACTIVE_RST = 32'h0000_0400;
    localparam logic [31:0] CW1_BUF_RST    = 32'h0000_0000;
    localparam logic [23:0] CW2_RST        = 24'h00_0000;
    localparam logic [31:0] FTW_RST        = 32'h0000_0000;
    // Sync clock divider.
    localparam int SYNC_DIV = 4;
    localparam int SYNC_CNT_W = 2;
    // Register select codes on the software port.
    localparam logic [1:0] ADDR_CW1 = 2'h0;
    localparam logic [1:0] ADDR_CW2 = 2'h1;
    localparam logic [1:0] ADDR_FTW = 2'h2;
    localparam logic [1:0] ADDR_STAT = 2'h3;
    // Lookup size.
    localparam int LUT_AW = 8;
    localparam int DAC_W  = 14;
endpackage

// ===== logic/dds_cos_lut.sv
/*
 * Cosine lookup: maps the top phase bits to an offset-binary DAC sample, registered.
 * Assumes phase arrives on the same clock.
 */
`timescale 1ns/100ps
module dds_cos_lut
(
    input  wire logic                          clk_sys,
    input  wire logic                          sys_rst,
    input  wire logic [dds_pkg::LUT_AW-1:0]    phase,
    output logic      [dds_pkg::DAC_W-1:0]     sample
);
    typedef struct packed
    {
        logic [dds_pkg::DAC_W-1:0] sample;
    } lut_s;

    lut_s st_q;
    lut_s st_d;
    logic [dds_pkg::DAC_W-1:0] cos_rom [0:(1<<dds_pkg::LUT_AW)-1];

    // Table built at elaboration; a real cos() keeps the ROM honest without a file.
    initial
    begin
        for (int i = 0; i < (1 << dds_pkg::LUT_AW); i++)
        begin
            cos_rom[i] = dds_pkg::DAC_W'(int'(8191.5 + 8191.0 *
                $cos(2.0 * 3.14159265358979 * i / (1 << dds_pkg::LUT_AW))));
        end
    end

    // Next sample is the table entry for the present phase.
    always_comb
    begin
        st_d = st_q;
        st_d.sample = cos_rom[phase];
    end

    // Sample register.
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign sample = st_q.sample;
endmodule

// ===== logic/dds_core_clock_control.sv
/*
 * Synthesis core with clock-mode control: phase accumulator, cosine output, buffered and
 * active control words, update strobe, profile pins, sync clock divider and clock mode.
 * Assumes all pins are asynchronous to clk_sys and the software port is synchronous.
 * Analog parts (PLL, oscillator) are represented by their enable and select outputs.
 */
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/100ps
module dds_core_clock_control
(
    input  wire logic                        clk_sys,
    input  wire logic                        sys_rst,
    input  wire logic [1:0]                  reg_addr,
    input  wire logic [31:0]                 reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic      [31:0]                 reg_rdata,
    input  wire logic                        update_strobe,
    input  wire logic                        profile_select_low,
    input  wire logic                        profile_select_high,
    input  wire logic                        keying_direction_input,
    input  wire logic                        sync_in,
    input  wire logic                        oscillator_mode_pin,
    output logic                             sync_clk_out,
    output logic [dds_pkg::DAC_W-1:0]        dac_sample,
    output logic [1:0]                       profile_active,
    output logic                             keying_dir,
    output logic                             pll_enable,
    output logic [4:0]                       pll_multiplier,
    output logic                             oscillator_enable,
    output logic                             crystal_out_enable,
    output logic                             core_clock_enable
);
    typedef struct packed
    {
        logic [31:0] cw1_buf;
        logic [31:0] cw1_act;
        logic [23:0] cw2_buf;
        logic [23:0] cw2_act;
        logic [31:0] ftw_buf;
        logic [31:0] ftw_act;
        logic [31:0] phase;
        logic [dds_pkg::SYNC_CNT_W-1:0] div;
        logic [2:0]  ps_lo_sy;
        logic [2:0]  ps_hi_sy;
        logic [2:0]  upd_sy;
        logic [1:0]  osk_sy;
        logic [1:0]  osm_sy;
        logic [1:0]  sin_sy;
        logic [1:0]  profile;
        logic        keying;
        logic [31:0] rdata;
    } core_s;

    core_s st_q;
    core_s st_d;
    logic  [dds_pkg::DAC_W-1:0] lut_out;

    // Multiplier in range selects the PLL; out of range bypasses it.
    function automatic logic mult_in_range(input logic [4:0] m);
        mult_in_range = (m >= dds_pkg::MULT_MIN) && (m <= dds_pkg::MULT_MAX);
    endfunction

    logic       transfer;
    logic       prof_change;
    logic       upd_rise;
    logic       sync_edge;
    logic [4:0] mult;

    // Transfer conditions; synchroniser stage 0 is never looked at here.
    always_comb
    begin
        upd_rise    = st_q.upd_sy[1] && !st_q.upd_sy[2];
        prof_change = (st_q.ps_lo_sy[1] != st_q.ps_lo_sy[2]) ||
                      (st_q.ps_hi_sy[1] != st_q.ps_hi_sy[2]);
        transfer    = upd_rise || prof_change;
        sync_edge   = (st_q.div == dds_pkg::SYNC_CNT_W'(dds_pkg::SYNC_DIV / 2 - 1));
        mult        = st_q.cw2_act[dds_pkg::CW2_MULT_MSB:dds_pkg::CW2_MULT_LSB];
    end

    // Next-state logic for the whole block.
    always_comb
    begin
        st_d = st_q;
        // Pins pass two flip-flops before use; a third stage on the profile and update pins gives edge history.
        st_d.ps_lo_sy = {st_q.ps_lo_sy[1:0], profile_select_low};
        st_d.ps_hi_sy = {st_q.ps_hi_sy[1:0], profile_select_high};
        st_d.upd_sy   = {st_q.upd_sy[1:0], update_strobe};
        st_d.osk_sy   = {st_q.osk_sy[0], keying_direction_input};
        st_d.osm_sy   = {st_q.osm_sy[0], oscillator_mode_pin};
        st_d.sin_sy   = {st_q.sin_sy[0], sync_in};
        // Divide-by-four counter gives the sync clock.
        st_d.div = st_q.div + dds_pkg::SYNC_CNT_W'(1);
        // Keying direction and profile are taken on the sync clock rising phase.
        if (sync_edge)
        begin
            st_d.keying  = st_q.osk_sy[1];
            st_d.profile = {st_q.ps_hi_sy[1], st_q.ps_lo_sy[1]};
        end
        // Software writes land in the buffer only.
        if (reg_wr)
        begin
            if (reg_addr == dds_pkg::ADDR_CW1)
                st_d.cw1_buf = reg_wdata;
            else if (reg_addr == dds_pkg::ADDR_CW2)
                st_d.cw2_buf = reg_wdata[23:0];
            else if (reg_addr == dds_pkg::ADDR_FTW)
                st_d.ftw_buf = reg_wdata;
        end
        // Transfer copies buffer to active; a same-cycle write is not yet included.
        if (transfer)
        begin
            st_d.cw1_act = st_q.cw1_buf;
            st_d.cw2_act = st_q.cw2_buf;
            st_d.ftw_act = st_q.ftw_buf;
        end
        // Accumulator: clear wins, a zero word simply holds phase.
        if (st_q.cw1_act[dds_pkg::CW1_CLR_PHASE_BIT])
            st_d.phase = '0;
        else
            st_d.phase = st_q.phase + st_q.ftw_act;
        // Read data: buffered words, or live status.
        if (reg_rd)
        begin
            if (reg_addr == dds_pkg::ADDR_CW1)
                st_d.rdata = st_q.cw1_buf;
            else if (reg_addr == dds_pkg::ADDR_CW2)
                st_d.rdata = {8'h00, st_q.cw2_buf};
            else if (reg_addr == dds_pkg::ADDR_FTW)
                st_d.rdata = st_q.ftw_buf;
            else
                st_d.rdata = {24'h00_0000, 3'h0, st_q.keying, st_q.profile,
                              st_q.sin_sy[1], st_q.osm_sy[1]};
        end
        else
        begin
            st_d.rdata = '0;
        end
    end

    // Single state register with synchronous reset to defaults.
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            st_q         <= '0;
            st_q.cw1_act <= dds_pkg::CW1_ACTIVE_RST;
            st_q.cw1_buf <= dds_pkg::CW1_BUF_RST;
            st_q.cw2_act <= dds_pkg::CW2_RST;
            st_q.cw2_buf <= dds_pkg::CW2_RST;
            st_q.ftw_act <= dds_pkg::FTW_RST;
            st_q.ftw_buf <= dds_pkg::FTW_RST;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // Cosine stage uses the top phase bits; the 32-bit sum wraps naturally.
    dds_cos_lut u_lut
    (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .phase   (st_q.phase[31 -: dds_pkg::LUT_AW]),
        .sample  (lut_out)
    );

    // Outputs; the analog clock path is steered by these selects.
    assign sync_clk_out       = st_q.div[dds_pkg::SYNC_CNT_W-1];
    assign dac_sample         = lut_out;
    assign reg_rdata          = st_q.rdata;
    assign profile_active     = st_q.profile;
    assign keying_dir         = st_q.keying;
    assign pll_enable         = mult_in_range(mult);
    assign pll_multiplier     = mult;
    assign oscillator_enable  = st_q.osm_sy[1];
    assign crystal_out_enable = st_q.osm_sy[1] &&
                                st_q.cw2_act[dds_pkg::CW2_XTAL_OUT_BIT];
    assign core_clock_enable  = !st_q.cw1_act[dds_pkg::CW1_CLKIN_OFF_BIT];

    // Clear bit held from reset keeps the phase at zero.
    clear_holds_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        st_q.cw1_act[dds_pkg::CW1_CLR_PHASE_BIT] |=> st_q.phase == 32'h0)
        else $error("Phase not held at zero while cleared.");

    // Phase advances by the tuning word when not cleared.
    phase_adds_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !st_q.cw1_act[dds_pkg::CW1_CLR_PHASE_BIT] && !transfer
        |=> st_q.phase == $past(st_q.phase) + $past(st_q.ftw_act))
        else $error("Phase did not advance by the tuning word.");

    // Sync clock has period four.
    sync_period_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        $rose(sync_clk_out) |-> ##2 $fell(sync_clk_out) ##2 $rose(sync_clk_out))
        else $error("Sync clock not at quarter rate.");

    // Profile change loads active words.
    profile_load_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        prof_change |=> st_q.ftw_act == $past(st_q.ftw_buf))
        else $error("Profile change did not transfer.");

    // Update edge loads active words.
    update_load_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        upd_rise |=> st_q.cw1_act == $past(st_q.cw1_buf))
        else $error("Update edge did not transfer.");

    // Active words only change on a transfer.
    active_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !transfer |=> $stable(st_q.ftw_act))
        else $error("Active word changed without transfer.");

    // PLL enable follows the multiplier range.
    pll_range_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        pll_enable == (mult > 5'h03 && mult < 5'h15))
        else $error("PLL enable disagrees with multiplier.");

    // Crystal output needs both the mode pin and the enable bit.
    xtal_out_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        crystal_out_enable |-> oscillator_enable && st_q.cw2_act[9])
        else $error("Crystal output enabled wrongly.");

    // Clock input disable stops the core clock.
    clk_off_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        st_q.cw1_act[4] |-> !core_clock_enable)
        else $error("Core clock not stopped.");

    // With the disable bit clear the core clock runs, whatever the multiplier.
    clk_on_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !st_q.cw1_act[4] |-> core_clock_enable)
        else $error("Core clock stopped without the disable bit.");

    // Keying direction moves only on the sync clock phase.
    keying_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !sync_edge |=> $stable(keying_dir))
        else $error("Keying direction moved off the sync phase.");

    // Profile moves only on the sync clock phase.
    profile_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !sync_edge |=> $stable(profile_active))
        else $error("Profile moved off the sync phase.");

    // On the sync phase the synchronised pins become the profile.
    profile_take_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        sync_edge |=> profile_active == $past({st_q.ps_hi_sy[1], st_q.ps_lo_sy[1]}))
        else $error("Profile not taken from the pins.");

    // A profile change copies word one as an update strobe would.
    profile_cw1_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        prof_change |=> st_q.cw1_act == $past(st_q.cw1_buf))
        else $error("Profile change did not transfer word one.");

    // Any transfer copies word two.
    transfer_cw2_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        transfer |=> st_q.cw2_act == $past(st_q.cw2_buf))
        else $error("Transfer did not copy word two.");

    // An update edge copies the tuning word.
    update_ftw_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        upd_rise |=> st_q.ftw_act == $past(st_q.ftw_buf))
        else $error("Update edge did not copy the tuning word.");

    // Active control words hold between transfers, so software cannot glitch them.
    cw1_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !transfer |=> $stable(st_q.cw1_act) && $stable(st_q.cw2_act))
        else $error("Active control word changed without transfer.");

    // Reset leaves the accumulator cleared until the first transfer.
    clear_reset_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        $fell(sys_rst) |-> st_q.cw1_act[10] && st_q.cw1_buf[10] == 1'b0)
        else $error("Clear-phase reset values wrong.");

    // The divider counts every cycle.
    div_step_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        1'b1 |=> st_q.div == $past(st_q.div) + 2'h1)
        else $error("Sync divider skipped a count.");

    // The sync clock rises when the divider leaves its middle count.
    sync_phase_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        $rose(sync_clk_out) |-> $past(st_q.div) == 2'h1)
        else $error("Sync clock rose on the wrong count.");

    // The multiplier output is the active field, bits 7 to 3.
    mult_field_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        pll_multiplier == st_q.cw2_act[7:3])
        else $error("Multiplier output not the active field.");

    // A stopped oscillator never drives its output buffer.
    xtal_off_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !oscillator_enable |-> !crystal_out_enable)
        else $error("Crystal output on with oscillator off.");

    // Read data stand only in the cycle after a read strobe.
    rdata_idle_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !reg_rd |=> reg_rdata == 32'h0)
        else $error("Read data present without a read.");

    // A read of word one returns its buffered copy.
    rdata_cw1_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        reg_rd && reg_addr == dds_pkg::ADDR_CW1 |=> reg_rdata == $past(st_q.cw1_buf))
        else $error("Word one read returned the wrong value.");

    // A tuning word write lands in the buffer on the next edge.
    ftw_write_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        reg_wr && reg_addr == dds_pkg::ADDR_FTW |=> st_q.ftw_buf == $past(reg_wdata))
        else $error("Tuning word write lost.");

    // The sync input stage follows the master's clock two edges late.
    sync_in_stage_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        1'b1 |=> st_q.sin_sy[1] == $past(st_q.sin_sy[0]))
        else $error("Sync input stage skipped.");
endmodule

// ===== verification/pin_host.sv
/*
 * Host controller model: drives the profile, keying and update pins in step with the
 * synthesis core's sync clock output, and plays a master device on the sync input.
 * Assumes the bench calls its tasks right after a rising edge of clk_sys.
 */
`timescale 1ns/100ps
module pin_host
(
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    input  wire logic sync_clk_out,
    output logic      update_strobe,
    output logic      profile_select_low,
    output logic      profile_select_high,
    output logic      keying_direction_input,
    output logic      sync_in
);
    logic [1:0] master_div_q;

    // A master device's quarter-rate sync clock feeds the slave's sync input.
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            master_div_q <= 2'h0;
        else
            master_div_q <= master_div_q + 2'h1;
    end
    assign sync_in = master_div_q[1];

    // Keying stays low until a scenario programs it, as an unused pin must be.
    initial
    begin
        update_strobe = 1'b0;
        profile_select_low = 1'b0;
        profile_select_high = 1'b0;
        keying_direction_input = 1'b0;
    end

    // The strobe is held a whole sync period so its edge is seen on a known phase.
    task automatic pulse_update();
        @(posedge sync_clk_out);
        update_strobe <= 1'b1;
        @(posedge sync_clk_out);
        update_strobe <= 1'b0;
    endtask

    // Profile pins move only just after a sync clock rising edge.
    task automatic set_profile(input logic [1:0] p);
        @(posedge sync_clk_out);
        {profile_select_high, profile_select_low} <= p;
    endtask

    // Keying direction moves only just after a sync clock rising edge.
    task automatic set_keying(input logic k);
        @(posedge sync_clk_out);
        keying_direction_input <= k;
    endtask
endmodule

// ===== verification/testbench.sv
/*
 * Self-checking bench for the synthesis core: register port tasks, pin host model,
 * transfers by strobe and by profile change, clock mode outputs and phase behaviour.
 * Assumes the design's package is compiled first.
 */
`timescale 1ns/100ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin errors++; \
    $display("unexpected at %0t: got %h want %h", $time, (a), (e)); end end
module testbench;
    logic                        clk_sys, sys_rst, reg_wr, reg_rd, oscillator_mode_pin;
    logic [1:0]                  reg_addr, profile_active;
    logic [31:0]                 reg_wdata, reg_rdata, rd_val;
    logic                        update_strobe, profile_select_low, profile_select_high;
    logic                        keying_direction_input, sync_in, sync_clk_out, keying_dir;
    logic                        pll_enable, oscillator_enable, crystal_out_enable;
    logic                        core_clock_enable;
    logic [4:0]                  pll_multiplier;
    logic [dds_pkg::DAC_W-1:0]   dac_sample, d0;
    logic [7:0]                  sh;
    int                          errors, tests_run;
    int                          cycles = 0;
    int                          mults[5] = '{3, 4, 20, 21, 0};

    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    dds_core_clock_control u_dds_core_clock_control (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .update_strobe(update_strobe),
        .profile_select_low(profile_select_low), .profile_select_high(profile_select_high),
        .keying_direction_input(keying_direction_input), .sync_in(sync_in),
        .oscillator_mode_pin(oscillator_mode_pin), .sync_clk_out(sync_clk_out),
        .dac_sample(dac_sample), .profile_active(profile_active), .keying_dir(keying_dir),
        .pll_enable(pll_enable), .pll_multiplier(pll_multiplier),
        .oscillator_enable(oscillator_enable), .crystal_out_enable(crystal_out_enable),
        .core_clock_enable(core_clock_enable));

    pin_host u_pin_host (.clk_sys(clk_sys), .sys_rst(sys_rst), .sync_clk_out(sync_clk_out),
        .update_strobe(update_strobe), .profile_select_low(profile_select_low),
        .profile_select_high(profile_select_high), .sync_in(sync_in),
        .keying_direction_input(keying_direction_input));

    // A write ends one idle cycle later so the strobe never rises in the edge it fell.
    task automatic reg_write(input logic [1:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        @(posedge clk_sys);
    endtask

    // Read data stand only in the cycle after the strobe, so they are taken there.
    task automatic reg_read(input logic [1:0] a);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 rd_val = reg_rdata;
        @(posedge clk_sys);
    endtask

    task automatic settle();
        repeat (8) @(posedge clk_sys);
        #1;
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Cuts a hang short; the whole run needs under two thousand cycles.
    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles == 6000)
        begin
            errors++;
            tally_and_finish();
        end
    end

    initial
    begin
        {reg_wr, reg_rd, reg_addr, reg_wdata, errors, tests_run} = '0;
        oscillator_mode_pin = 1'b1;
        sys_rst = 1'b1;
        repeat (16) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        reg_read(dds_pkg::ADDR_CW1); `CHK(rd_val, 32'h0)
        reg_read(dds_pkg::ADDR_CW2); `CHK(rd_val, 32'h0)
        #1 `CHK({core_clock_enable, pll_enable, pll_multiplier}, 7'h40)
        // Tuning word buffered only: phase must stay cleared at cosine zero.
        reg_write(dds_pkg::ADDR_FTW, 32'h0100_0000);
        settle(); d0 = dac_sample;
        repeat (4) @(posedge clk_sys);
        #1 `CHK({dac_sample, dac_sample[13]}, {d0, 1'b1})
        for (int i = 0; i < 8; i++)
        begin
            @(posedge clk_sys);
            #1 sh = {sh[6:0], sync_clk_out};
        end
        `CHK({sh[7:4], sh[3:2]}, {sh[3:0], ~sh[1:0]})
        reg_write(dds_pkg::ADDR_CW2, 32'h0000_0228);
        reg_read(dds_pkg::ADDR_CW2); `CHK({rd_val, pll_multiplier}, {32'h228, 5'h0})
        u_pin_host.pulse_update(); settle();
        `CHK({pll_multiplier, pll_enable, crystal_out_enable}, 7'h17)
        // One lookup step per cycle: half a turn differs, a full turn wraps back.
        d0 = dac_sample;
        repeat (128) @(posedge clk_sys);
        #1 `CHK(dac_sample === d0, 1'b0)
        repeat (128) @(posedge clk_sys);
        #1 `CHK(dac_sample, d0)
        reg_write(dds_pkg::ADDR_FTW, 32'h8000_0000);
        u_pin_host.set_profile(2'h1); settle();
        `CHK(profile_active, 2'h1)
        d0 = dac_sample;
        @(posedge clk_sys); #1 `CHK(dac_sample === d0, 1'b0)
        @(posedge clk_sys); #1 `CHK(dac_sample, d0)
        reg_write(dds_pkg::ADDR_CW1, 32'h0000_0400);
        u_pin_host.set_profile(2'h2); settle(); d0 = dac_sample;
        repeat (3) @(posedge clk_sys);
        #1 `CHK({dac_sample, dac_sample[13], profile_active}, {d0, 1'b1, 2'h2})
        reg_write(dds_pkg::ADDR_CW1, 32'h0);
        reg_write(dds_pkg::ADDR_FTW, 32'h0);
        u_pin_host.set_profile(2'h3); settle(); d0 = dac_sample;
        repeat (3) @(posedge clk_sys);
        #1 `CHK({dac_sample, profile_active}, {d0, 2'h3})
        foreach (mults[i])
        begin
            reg_write(dds_pkg::ADDR_CW2, 32'(mults[i]) << 3);
            // Lock time is not modelled; the host only waits before relying on it.
            u_pin_host.pulse_update(); settle();
            `CHK({pll_multiplier, pll_enable}, {5'(mults[i]), mults[i] >= 4 && mults[i] <= 20})
        end
        reg_write(dds_pkg::ADDR_CW2, 32'h0000_00a0);
        reg_write(dds_pkg::ADDR_CW1, 32'h0000_0010);
        u_pin_host.pulse_update(); settle();
        `CHK({core_clock_enable, pll_enable, pll_multiplier}, 7'h34)
        u_pin_host.set_keying(1'b1);
        oscillator_mode_pin <= 1'b0;
        settle();
        `CHK({keying_dir, oscillator_enable, crystal_out_enable}, 3'h4)
        reg_write(dds_pkg::ADDR_STAT, 32'hffff_ffff);
        reg_read(dds_pkg::ADDR_STAT);
        `CHK({rd_val[31:2], rd_val[0]}, {27'h0, 3'h7, 1'b0})
        // Reads two cycles apart see the master's half-period sync input inverted.
        sh[0] = rd_val[1];
        reg_read(dds_pkg::ADDR_STAT);
        `CHK(rd_val[1], ~sh[0])
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        reg_read(dds_pkg::ADDR_CW1);
        #1 `CHK({rd_val, core_clock_enable, pll_multiplier, profile_active}, {32'h0, 8'h80})
        tally_and_finish();
    end
endmodule
